// ### rtl/rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Shift-style FIFO: entry 0 is always the head, so read data is a register
module rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic flush,
  // Fill side
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic empty
);

  logic [WIDTH-1:0] entry_reg [0:DEPTH-1];
  logic [CW-1:0] count_reg;
  logic do_pop;
  logic do_push;

  assign do_pop = pop && (count_reg != '0);
  assign do_push = push_valid && push_ready;
  assign push_ready = (count_reg != CW'(DEPTH)) || do_pop;
  assign head_data = entry_reg[0];
  assign empty = (count_reg == '0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || flush)
      count_reg <= '0;
    else if (do_push && !do_pop)
      count_reg <= count_reg + CW'(1);
    else if (do_pop && !do_push)
      count_reg <= count_reg - CW'(1);
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      logic [WIDTH-1:0] above;
      // Top slot refills with zeros, so an emptied head reads zero
      if (i == DEPTH - 1)
      begin : g_top
        assign above = '0;
      end
      else
      begin : g_mid
        assign above = entry_reg[i + 1];
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn || flush)
          entry_reg[i] <= '0;
        else if (do_pop && do_push)
          entry_reg[i] <= (CW'(i + 1) == count_reg) ? push_data : above;
        else if (do_pop)
          entry_reg[i] <= above;
        else if (do_push && CW'(i) == count_reg)
          entry_reg[i] <= push_data;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### rtl/usart_receive_buffer_flags.sv
// Contract
// - Reading data advances the FIFO; ninth bit and flags follow next frame.
// - Receive-complete reads one while unread data remains, else zero.
// - Clearing receiver enable flushes the buffer and clears receive-complete.
// - Interrupt requested continuously while flag set, enable and global on.
// - Error flags are stored with their frame and shown at read position.
// - Software writes never alter error flags; software writes them zero.
// - Receiver error flags never raise an interrupt.
// - Frame error is one when the first stop bit sampled zero.
// - Frame error ignores the stop-bit-count setting.
// - Overrun when buffer full, shift register waiting, and new start.
// - Overrun clears once a frame moves into the buffer.
// - Parity check only when enabled; odd select picks the sense.
// - Parity error stored only if enabled at reception; else reads zero.
// - Disabling the receiver is immediate; ongoing frame lost, pin released.
// - Unused upper data bits read zero for sizes below eight.
// - Frame transferred at first stop bit; second stop bit ignored.
`timescale 1ns/1ps
`default_nettype none
`include "usart_rx_defines.svh"

module usart_receive_buffer_flags #(
  parameter int ADDR_W = 5,
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Recovered bit stream from the clock and data recovery logic
  input wire logic rx_start_pulse,
  input wire logic rx_bit_pulse,
  input wire logic rx_bit_value,
  // Interrupt and pin control
  input wire logic global_irq_en,
  output logic rx_irq,
  output logic rx_pin_override
);

  localparam int ENTRY_W = $bits(usart_rx_pkg::rx_entry_type);
  // Named so its fields can be selected; a bare literal cannot be
  localparam logic [7:0] CTRL_C_INIT = `CTRL_C_RESET;

  // Output flops
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic rx_irq_reg;
  logic rx_pin_override_reg;

  // Write channel holding
  logic aw_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic w_have_reg;
  logic [7:0] wbyte_reg;
  logic wstrb0_reg;

  // Software controls
  logic rx_enable_bit;
  logic rx_complete_irq_en;
  logic tx_ninth_bit;
  logic [2:0] char_size_sel;
  logic parity_enable_bit;
  logic parity_odd_sel;
  logic stop_bit_count_sel;

  // Receiver state
  usart_rx_pkg::rx_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] nbits_reg;
  logic [8:0] shift_reg;
  logic frame_par_en_reg;
  logic frame_par_odd_reg;
  logic par_bit_reg;
  logic hold_valid_reg;
  usart_rx_pkg::rx_entry_type hold_reg;
  logic dor_pend_reg;

  // FIFO wiring
  usart_rx_pkg::rx_entry_type push_entry;
  usart_rx_pkg::rx_entry_type head;
  logic [ENTRY_W-1:0] head_vec;
  logic fifo_push;
  logic fifo_ready;
  logic fifo_empty;
  logic fifo_pop;
  logic flush;

  // Decoded handshakes, character size, parity and receive-complete flag
  logic do_write;
  logic ar_take;
  logic [3:0] char_bits;
  logic parity_calc;
  logic rx_complete_flag;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign rx_irq = rx_irq_reg;
  assign rx_pin_override = rx_pin_override_reg;

  assign head = usart_rx_pkg::rx_entry_type'(head_vec);
  assign rx_complete_flag = !fifo_empty;
  assign flush = !rx_enable_bit;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign ar_take = arvalid && arready_reg;
  assign fifo_pop = ar_take && (araddr == ADDR_W'(`DATA_OFFSET));
  assign fifo_push = hold_valid_reg && fifo_ready;

  always_comb
  begin
    push_entry = hold_reg;
    push_entry.overrun = dor_pend_reg;
  end

  always_comb
  begin
    if (char_size_sel == `CHAR_SIZE_NINE)
      char_bits = `NINE_BITS;
    else
      char_bits = `CHAR_SIZE_BASE + {2'h0, char_size_sel[1:0]};
  end

  assign parity_calc = (^shift_reg) ^ frame_par_odd_reg;

  rx_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(flush),
    .push_valid(fifo_push),
    .push_ready(fifo_ready),
    .push_data(push_entry),
    .pop(fifo_pop),
    .head_data(head_vec),
    .empty(fifo_empty)
  );

  // Write address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      awready_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wbyte_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      wready_reg <= 1'b0;
    end
    else
    begin
      if (awvalid && awready_reg)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= awaddr;
        awready_reg <= 1'b0;
      end
      else if (do_write)
        aw_have_reg <= 1'b0;
      else if (!aw_have_reg && !bvalid_reg)
        awready_reg <= 1'b1;
      if (wvalid && wready_reg)
      begin
        w_have_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wstrb0_reg <= wstrb[0];
        wready_reg <= 1'b0;
      end
      else if (do_write)
        w_have_reg <= 1'b0;
      else if (!w_have_reg && !bvalid_reg)
        wready_reg <= 1'b1;
    end
  end

  // Write response is raised on the same edge as the register update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      case (awaddr_reg)
        ADDR_W'(`DATA_OFFSET), ADDR_W'(`STATUS_OFFSET),
        ADDR_W'(`CTRL_B_OFFSET), ADDR_W'(`CTRL_C_OFFSET):
          bresp_reg <= `RESP_OKAY;
        default:
          bresp_reg <= `RESP_SLVERR;
      endcase
    end
    else if (bvalid_reg && bready)
      bvalid_reg <= 1'b0;
  end

  // Control registers; status writes are accepted but change nothing
  // status writes ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_enable_bit <= 1'b0;
      rx_complete_irq_en <= 1'b0;
      tx_ninth_bit <= 1'b0;
      char_size_sel <= CTRL_C_INIT[`CC_CHAR_SIZE_LSB +: 3];
      parity_enable_bit <= CTRL_C_INIT[`CC_PARITY_EN_BIT];
      parity_odd_sel <= CTRL_C_INIT[`CC_PARITY_ODD_BIT];
      stop_bit_count_sel <= CTRL_C_INIT[`CC_STOP_SEL_BIT];
    end
    else if (do_write && wstrb0_reg)
    begin
      if (awaddr_reg == ADDR_W'(`CTRL_B_OFFSET))
      begin
        rx_complete_irq_en <= wbyte_reg[`CB_RX_IRQ_EN_BIT];
        rx_enable_bit <= wbyte_reg[`CB_RX_ENABLE_BIT];
        tx_ninth_bit <= wbyte_reg[`CB_TX_NINTH_BIT];
      end
      if (awaddr_reg == ADDR_W'(`CTRL_C_OFFSET))
      begin
        parity_enable_bit <= wbyte_reg[`CC_PARITY_EN_BIT];
        parity_odd_sel <= wbyte_reg[`CC_PARITY_ODD_BIT];
        stop_bit_count_sel <= wbyte_reg[`CC_STOP_SEL_BIT];
        char_size_sel <= wbyte_reg[`CC_CHAR_SIZE_LSB +: 3];
      end
    end
  end

  // Read channel: data captured at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ar_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      case (araddr)
        ADDR_W'(`DATA_OFFSET):
          rdata_reg[7:0] <= head.data;
        ADDR_W'(`STATUS_OFFSET):
        begin
          rdata_reg[`ST_RX_COMPLETE_BIT] <= rx_complete_flag;
          rdata_reg[`ST_FRAME_ERR_BIT] <= head.frame_err;
          rdata_reg[`ST_OVERRUN_BIT] <= head.overrun;
          rdata_reg[`ST_PARITY_ERR_BIT] <= head.parity_err;
        end
        ADDR_W'(`CTRL_B_OFFSET):
        begin
          rdata_reg[`CB_RX_IRQ_EN_BIT] <= rx_complete_irq_en;
          rdata_reg[`CB_RX_ENABLE_BIT] <= rx_enable_bit;
          rdata_reg[`CB_RX_NINTH_BIT] <= head.ninth;
          rdata_reg[`CB_TX_NINTH_BIT] <= tx_ninth_bit;
        end
        ADDR_W'(`CTRL_C_OFFSET):
        begin
          rdata_reg[`CC_PARITY_EN_BIT] <= parity_enable_bit;
          rdata_reg[`CC_PARITY_ODD_BIT] <= parity_odd_sel;
          rdata_reg[`CC_STOP_SEL_BIT] <= stop_bit_count_sel;
          rdata_reg[`CC_CHAR_SIZE_LSB +: 3] <= char_size_sel;
        end
        default:
          rresp_reg <= `RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  // Frame assembly; a frame ends at its first stop bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= usart_rx_pkg::RX_IDLE;
      bit_cnt_reg <= 4'h0;
      nbits_reg <= 4'h0;
      shift_reg <= 9'h000;
      frame_par_en_reg <= 1'b0;
      frame_par_odd_reg <= 1'b0;
      par_bit_reg <= 1'b0;
    end
    else if (!rx_enable_bit)
      state_reg <= usart_rx_pkg::RX_IDLE;
    else
    begin
      unique case (state_reg)
        usart_rx_pkg::RX_IDLE:
          // A start with full buffer and waiting frame is lost
          if (rx_start_pulse && (fifo_ready || !hold_valid_reg))
          begin
            state_reg <= usart_rx_pkg::RX_DATA;
            bit_cnt_reg <= 4'h0;
            nbits_reg <= char_bits;
            shift_reg <= 9'h000;
            frame_par_en_reg <= parity_enable_bit;
            frame_par_odd_reg <= parity_odd_sel;
          end
        usart_rx_pkg::RX_DATA:
          if (rx_bit_pulse)
          begin
            shift_reg[bit_cnt_reg] <= rx_bit_value;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg + 4'h1 == nbits_reg)
              state_reg <= frame_par_en_reg ? usart_rx_pkg::RX_PARITY
                                            : usart_rx_pkg::RX_STOP;
          end
        usart_rx_pkg::RX_PARITY:
          if (rx_bit_pulse)
          begin
            par_bit_reg <= rx_bit_value;
            state_reg <= usart_rx_pkg::RX_STOP;
          end
        usart_rx_pkg::RX_STOP:
          if (rx_bit_pulse)
            state_reg <= usart_rx_pkg::RX_IDLE;
      endcase
    end
  end

  // Completed frame waits here when the buffer is full
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_enable_bit)
    begin
      hold_valid_reg <= 1'b0;
      hold_reg <= '0;
    end
    else if (state_reg == usart_rx_pkg::RX_STOP && rx_bit_pulse)
    begin
      hold_valid_reg <= 1'b1;
      hold_reg.data <= shift_reg[7:0];
      hold_reg.ninth <= shift_reg[8];
      hold_reg.frame_err <= !rx_bit_value;
      hold_reg.parity_err <= frame_par_en_reg &&
                             (parity_calc != par_bit_reg);
      hold_reg.overrun <= 1'b0;
    end
    else if (fifo_push)
      hold_valid_reg <= 1'b0;
  end

  // Overrun pending travels with the next frame that gets in
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_enable_bit)
      dor_pend_reg <= 1'b0;
    else if (state_reg == usart_rx_pkg::RX_IDLE && rx_start_pulse &&
             hold_valid_reg && !fifo_ready)
      dor_pend_reg <= 1'b1;
    else if (fifo_push)
      dor_pend_reg <= 1'b0;
  end

  // Level request; error flags deliberately play no part
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_irq_reg <= 1'b0;
      rx_pin_override_reg <= 1'b0;
    end
    else
    begin
      rx_irq_reg <= rx_complete_flag && rx_complete_irq_en &&
                    global_irq_en && !flush;
      rx_pin_override_reg <= rx_enable_bit;
    end
  end

endmodule

`default_nettype wire

// ### rtl/usart_rx_defines.svh
`ifndef USART_RX_DEFINES_SVH
`define USART_RX_DEFINES_SVH

// Register byte offsets
`define DATA_OFFSET 5'h00
`define STATUS_OFFSET 5'h04
`define CTRL_B_OFFSET 5'h08
`define CTRL_C_OFFSET 5'h0C

// Status register bits
`define ST_RX_COMPLETE_BIT 7
`define ST_FRAME_ERR_BIT 4
`define ST_OVERRUN_BIT 3
`define ST_PARITY_ERR_BIT 2

// Control register B bits
`define CB_RX_IRQ_EN_BIT 7
`define CB_RX_ENABLE_BIT 4
`define CB_RX_NINTH_BIT 1
`define CB_TX_NINTH_BIT 0

// Control register C bits
`define CC_PARITY_EN_BIT 5
`define CC_PARITY_ODD_BIT 4
`define CC_STOP_SEL_BIT 3
`define CC_CHAR_SIZE_LSB 0

// Reset values and codes
`define CTRL_C_RESET 8'h03
`define CHAR_SIZE_NINE 3'h7
`define CHAR_SIZE_BASE 4'h5
`define NINE_BITS 4'h9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/usart_rx_pkg.sv
package usart_rx_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_type;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } rx_entry_type;

endpackage

// ### verif/serial_source.sv
`timescale 1ns/1ps
`default_nettype none
module serial_source (
  // Clock
  input wire logic aclk,
  // Recovered bit stream
  output logic start_pulse,
  output logic bit_pulse,
  output logic bit_value
);
  int gap = 1;
  int cut = 0;
  logic odd = 1'b0;
  logic two_stop = 1'b0;
  initial
  begin
    start_pulse = 1'b0;
    bit_pulse = 1'b0;
    bit_value = 1'b0;
  end
  // Value is only meaningful with the pulse, so it flips afterwards
  task automatic pulse(input logic v);
    bit_pulse <= 1'b1;
    bit_value <= v;
    @(posedge aclk);
    bit_pulse <= 1'b0;
    bit_value <= ~v;
    repeat (gap) @(posedge aclk);
  endtask
  task automatic send(input logic [8:0] d, input int n, input int par,
    input logic stopv);
    int k;
    logic p;
    // even equals data xor, odd inverts, par 2 corrupts
    p = ^(d & ((9'h001 << n) - 9'h001)) ^ odd ^ (par == 2);
    @(posedge aclk);
    start_pulse <= 1'b1;
    @(posedge aclk);
    start_pulse <= 1'b0;
    repeat (gap) @(posedge aclk);
    for (k = 0; k < n && (cut == 0 || k < cut); k++)
      pulse(d[k]);
    if (cut == 0)
    begin
      if (par != 0)
        pulse(p);
      // first stop carries the value, a second one follows when two_stop is set
      pulse(stopv);
      if (two_stop)
        pulse(1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ### verif/usart_receive_buffer_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "usart_rx_defines.svh"
module usart_receive_buffer_flags_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [4:0] araddr = 5'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic start_pulse;
  logic bit_pulse;
  logic bit_value;
  logic global_irq_en = 1'b0;
  logic rx_irq;
  logic rx_pin_override;
  int fail_count = 0;
  int comparisons = 0;
  int i;
  logic [8:0] e;
  logic [23:0] t;
  // Control C, parity kind, stop value, expected status
  logic [23:0] tab [7] = '{24'h030090, 24'h0B0180, 24'h0B0090,
    24'h231180, 24'h232184, 24'h332184, 24'h331180};
  usart_receive_buffer_flags DUT (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rx_start_pulse(start_pulse), .rx_bit_pulse(bit_pulse),
    .rx_bit_value(bit_value), .global_irq_en, .rx_irq, .rx_pin_override);
  serial_source src (.aclk, .start_pulse, .bit_pulse, .bit_value);
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input logic ok);
    if (!ok)
    begin
      fail_count++;
      $display("wrong value at %0t: no answer in time", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
    input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    guard(n < 40);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] x,
    input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    guard(n < 40);
    chk({30'h0, rresp}, {30'h0, er});
    if (er == 2'h0)
      chk(rdata, {24'h0, x});
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 400 && rx_irq !== 1'b1; n++)
      @(posedge aclk);
    guard(n < 400);
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`STATUS_OFFSET, 8'h00);
    rd(`CTRL_B_OFFSET, 8'h00);
    rd(`CTRL_C_OFFSET, `CTRL_C_RESET);
    rd(5'h10, 8'h00, `RESP_SLVERR);
    wr(5'h14, 8'hFF, `RESP_SLVERR);
    wr(`STATUS_OFFSET, 8'h1C);
    rd(`STATUS_OFFSET, 8'h00);
    global_irq_en <= 1'b1;
    wr(`CTRL_B_OFFSET, 8'h90);
    for (i = 0; i < 5; i++)
    begin
      wr(`CTRL_C_OFFSET, (i == 4) ? 8'h07 : 8'(i));
      src.send(9'h1A5, (i == 4) ? 9 : i + 5, 0, 1'b1);
      wait_irq();
      e = 9'h1A5 & ((9'h001 << ((i == 4) ? 9 : i + 5)) - 9'h001);
      rd(`STATUS_OFFSET, 8'h80);
      rd(`CTRL_B_OFFSET, {6'h24, i == 4, 1'b0});
      rd(`DATA_OFFSET, e[7:0]);
      rd(`STATUS_OFFSET, 8'h00);
    end
    for (i = 0; i < 7; i++)
    begin
      t = tab[i];
      src.odd = t[20];
      src.two_stop = t[19];
      wr(`CTRL_C_OFFSET, t[23:16]);
      src.send(9'h05A, 8, int'(t[13:12]), t[8]);
      wait_irq();
      rd(`STATUS_OFFSET, t[7:0]);
      rd(`DATA_OFFSET, 8'h5A);
    end
    global_irq_en <= 1'b0;
    src.odd = 1'b0;
    src.two_stop = 1'b0;
    wr(`CTRL_C_OFFSET, 8'h03);
    src.send(9'h011, 8, 0, 1'b1);
    src.send(9'h022, 8, 0, 1'b0);
    src.send(9'h033, 8, 0, 1'b1);
    src.send(9'h044, 8, 0, 1'b1);
    repeat (4) @(posedge aclk);
    chk({31'h0, rx_irq}, 32'h0);
    rd(`STATUS_OFFSET, 8'h80);
    rd(`DATA_OFFSET, 8'h11);
    rd(`STATUS_OFFSET, 8'h90);
    rd(`DATA_OFFSET, 8'h22);
    rd(`STATUS_OFFSET, 8'h88);
    rd(`DATA_OFFSET, 8'h33);
    rd(`STATUS_OFFSET, 8'h00);
    src.send(9'h055, 8, 0, 1'b1);
    repeat (4) @(posedge aclk);
    rd(`STATUS_OFFSET, 8'h80);
    rd(`DATA_OFFSET, 8'h55);
    global_irq_en <= 1'b1;
    src.send(9'h066, 8, 0, 1'b1);
    src.send(9'h077, 8, 0, 1'b1);
    wait_irq();
    wr(`CTRL_B_OFFSET, 8'h80);
    rd(`STATUS_OFFSET, 8'h00);
    wr(`CTRL_B_OFFSET, 8'h90);
    src.cut = 3;
    src.send(9'h0FF, 8, 0, 1'b1);
    wr(`CTRL_B_OFFSET, 8'h80);
    @(posedge aclk);
    chk({31'h0, rx_pin_override}, 32'h0);
    wr(`CTRL_B_OFFSET, 8'h90);
    @(posedge aclk);
    chk({31'h0, rx_pin_override}, 32'h1);
    src.cut = 0;
    src.gap = 3;
    src.send(9'h0C3, 8, 0, 1'b1);
    wait_irq();
    rd(`STATUS_OFFSET, 8'h80);
    rd(`DATA_OFFSET, 8'hC3);
    rd(`STATUS_OFFSET, 8'h00);
    repeat (4) @(posedge aclk);
    chk({31'h0, rx_irq}, 32'h0);
    tally_and_finish();
  end
endmodule
bind usart_receive_buffer_flags usart_rx_props #(.ADDR_W(ADDR_W)) props (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid, .global_irq_en, .rx_irq,
  .rx_pin_override);
`default_nettype wire

// ### verif/usart_rx_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "usart_rx_defines.svh"
module usart_rx_props #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Interrupt and pin
  input wire logic global_irq_en,
  input wire logic rx_irq,
  input wire logic rx_pin_override
);
  logic wr_b;
  assign wr_b = awvalid && awready && wvalid && wready && wstrb[0]
    && awaddr == `CTRL_B_OFFSET;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_quiet;
    $rose(aresetn) |-> !rx_irq && !rx_pin_override && !bvalid && !rvalid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs active after reset");
  property p_irq_gate;
    rx_irq |-> $past(global_irq_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without global enable");
  // Bus traffic may pop or reconfigure, so only quiet stretches count
  property p_irq_hold;
    (rx_irq && global_irq_en && !arvalid && !$past(arvalid) && !rvalid
      && !$past(rvalid) && !awvalid && !$past(awvalid) && !bvalid
      && !$past(bvalid)) ##1 global_irq_en |-> rx_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped with data unread");
  property p_dis;
    wr_b && !wdata[`CB_RX_ENABLE_BIT] |-> ##[1:3] !rx_pin_override;
  endproperty
  a_dis: assert property (p_dis)
    else $error("pin still held after disable");
  property p_en;
    wr_b && wdata[`CB_RX_ENABLE_BIT] |-> ##[1:3] rx_pin_override;
  endproperty
  a_en: assert property (p_en)
    else $error("pin not taken after enable");
  property p_flush;
    wr_b && !wdata[`CB_RX_ENABLE_BIT] |-> ##[1:5] !rx_irq;
  endproperty
  a_flush: assert property (p_flush)
    else $error("interrupt survives flush");
  property p_idle;
    !rx_pin_override && !$past(rx_pin_override) && !rx_irq |=> !rx_irq;
  endproperty
  a_idle: assert property (p_idle)
    else $error("interrupt while receiver off");
  property p_wr_ans;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late");
  property p_rd_ans;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read response late");
  c_irq: cover property (rx_irq);
  c_dis: cover property (wr_b && !wdata[`CB_RX_ENABLE_BIT]);
  c_read: cover property (arvalid && arready);
endmodule
`default_nettype wire
